// >>> hdl/card_pkg.sv
// Shared constants and carrier types for the card start-up session block.
package card_pkg;
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_GTB = 4'h4;
  localparam logic [3:0] OFS_SEC = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;
  localparam logic [7:0] CFG_TA1_RST = 8'h97;
  localparam logic [5:0] CFG_CLASS_RST = 6'h03;
  localparam logic [1:0] CFG_STOP_RST = 2'h3;
  localparam logic [7:0] GTB_RST = 8'h00;
  localparam logic [7:0] ATR_TS = 8'h3b;
  localparam logic [7:0] ATR_T0 = 8'h97;
  localparam logic [7:0] ATR_TD1 = 8'h80;
  localparam logic [7:0] ATR_TD2 = 8'h3f;
  localparam logic [7:0] HIST_CAT = 8'h80;
  localparam logic [7:0] HIST_TAG_SVC = 8'h31;
  localparam logic [7:0] HIST_TAG_CAP = 8'h73;
  localparam logic [7:0] HIST_SVC_VAL = 8'ha0;
  localparam logic [23:0] HIST_CAP_VAL = 24'h000000;
  localparam logic [3:0] ATR_LAST = 4'he;
  localparam logic [5:0] CLASS_A_ONLY = 6'h01;
  localparam logic [1:0] STOP_NONE = 2'h0;
  localparam logic [1:0] STOP_ANY = 2'h3;
  localparam logic [7:0] PPSS = 8'hff;
  localparam logic [7:0] FD_DEF = 8'h11;
  localparam logic [7:0] FD_512_8 = 8'h94;
  localparam logic [7:0] FD_512_16 = 8'h95;
  typedef struct packed {
    logic spec;
    logic [1:0] stop;
    logic [5:0] vclass;
    logic [7:0] ta1;
  } cfg_t;
  typedef struct packed {
    logic none;
    logic lowimp;
    logic usb;
    logic clf;
    logic sc;
    logic p2p;
    logic euicc;
  } feat_t;
  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_ATR = 3'b001,
    ST_WAIT = 3'b010,
    ST_PRX = 3'b011,
    ST_PTX = 3'b100,
    ST_RUN = 3'b101
  } state_t;
endpackage : card_pkg

// >>> hdl/card_session.sv
// Card-side answer to reset, PPS acceptance and reset-mode logic.
`timescale 1ns/1ps
// Operation
// RULE1: First historical byte sent is the category indicator 80h.
// RULE2: Historical objects follow: tag 31 object first, then tag 73 object.
// RULE3: Factor pairs 512/8 and 512/16 accepted besides default 372/1.
// RULE4: TA1 of the answer carries the supported F and D factors.
// RULE5: Global bytes follow only a TDi (i above 1) indicating T=15.
// RULE6: Global tB byte of zero decodes as no extra parameters.
// RULE7: b8 and b5 set report low-impedance driver protocol available.
// RULE8: With b8, bits 7, 6, 4 and 2 flag USB, CLF, channel, provisioning.
// RULE9: b8, b4 and b3 set report secured platform exchange required.
// RULE10: Terminal picks PPS1 within the advertised factor range.
// RULE11: Terminal sends PPS2 only when global tB is present, same coding.
// RULE12: Terminal tries its top speed via PPS before falling back to 372/1.
// RULE13: Cold reset enters negotiable mode and clears security status.
// RULE14: Warm reset clears security; specific mode keeps previous factors.
// RULE15: Answer to reset is byte-identical after every warm reset in session.
// RULE16: Any non-A-only class forces clock stop supported in global tA.
// RULE17: Terminal obeys the clock-stop indication in all conditions.
// RULE18: Terminal waits 1860 clocks after last response before clock stop.
// RULE19: Terminal waits 744 clocks after clock restart before a command.
// RULE20: Terminal resets the card on announced but missing characters.
// RULE21: Terminal rejects only after three consecutive faulty answers.
// RULE22: Card repeats characters on parity error in all T=0 traffic; a rejected final check byte of the answer or echo is not repeated.
// RULE23: Every answer to reset carries the T=15 global bytes.
// RULE24: The TD chain announces exactly the bytes sent, locating tA and tB.
module card_session
  import card_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic contact_act,
  input wire logic card_rst_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_nack,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_perr,
  output logic rx_repeat,
  output logic negotiable,
  output logic [7:0] fidi,
  output logic lowimp_sel,
  output logic security
);
  // Decodes the first global tB byte; shared by the status view and PPS2 check.
  function automatic feat_t decode_gtb(input logic [7:0] b);
    feat_t f;
    f.none = (b == 8'h00); // RULE6
    f.lowimp = b[7] & b[4]; // RULE7
    f.usb = b[7] & b[6]; // RULE8
    f.clf = b[7] & b[5]; // RULE8
    f.sc = b[7] & b[3]; // RULE8
    f.euicc = b[7] & b[1]; // RULE8
    f.p2p = b[7] & b[3] & b[2]; // RULE9
    return f;
  endfunction : decode_gtb

  // Answer body, TS through the last historical byte; the check byte is added apart.
  function automatic logic [7:0] atr_body(input logic [3:0] i, input cfg_t c,
                                          input logic [7:0] g);
    logic [1:0] stop;
    stop = (c.vclass != CLASS_A_ONLY && c.stop == STOP_NONE) ? STOP_ANY : c.stop; // RULE16
    case (i)
      4'h0: return ATR_TS;
      4'h1: return ATR_T0; // RULE24
      4'h2: return c.ta1; // RULE4
      4'h3: return ATR_TD1; // RULE24
      4'h4: return ATR_TD2; // RULE5
      4'h5: return {stop, c.vclass}; // RULE23
      4'h6: return g; // RULE23
      4'h7: return HIST_CAT; // RULE1
      4'h8: return HIST_TAG_SVC; // RULE2
      4'h9: return HIST_SVC_VAL;
      4'ha: return HIST_TAG_CAP; // RULE2
      4'hb: return HIST_CAP_VAL[23:16];
      4'hc: return HIST_CAP_VAL[15:8];
      4'hd: return HIST_CAP_VAL[7:0];
      default: return 8'h00;
    endcase
  endfunction : atr_body

  cfg_t cfg_q, atr_cfg_q;
  logic [7:0] gtb_q, atr_gtb_q;
  state_t st_q, st_d;
  logic [3:0] idx_q, idx_d;
  logic [7:0] pps_q [0:5];
  logic [2:0] pcnt_q;
  logic cold_q, crst_q, sec_q, neg_q, lowimp_q, rep_q, txv_q;
  logic [7:0] fidi_q, txb_q, tck;
  logic [31:0] rdata_q;
  feat_t gfeat, pfeat;
  logic [7:0] pps_x;
  logic [2:0] plen;

  // Every check in this module runs on the one clock and is off while the block is in reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // The check byte is recomputed from the snapshot, so it always matches the body.
  always_comb
  begin
    tck = 8'h00;
    for (int k = 1; k <= 13; k++)
    begin
      tck = tck ^ atr_body(4'(k), atr_cfg_q, atr_gtb_q);
    end
  end

  wire rst_rise = card_rst_n & ~crst_q;
  wire tx_take = txv_q & tx_ready;
  wire rx_take = rx_valid & ~rx_perr;
  assign gfeat = decode_gtb(atr_gtb_q);
  assign pfeat = decode_gtb(pps_q[3]);
  assign plen = 3'd3 + {2'b0, pps_q[1][4]} + {2'b0, pps_q[1][5]} + {2'b0, pps_q[1][6]};
  assign pps_x = pps_q[0] ^ pps_q[1] ^ pps_q[2] ^ pps_q[3] ^ pps_q[4] ^ pps_q[5];
  wire pps1_ok = ~pps_q[1][4] || pps_q[2] == FD_DEF || pps_q[2] == FD_512_8
                 || pps_q[2] == FD_512_16; // RULE3
  wire pps2_ok = ~pps_q[1][5] || (~gfeat.none && (pps_q[3] & ~atr_gtb_q) == 8'h00);
  wire pps_ok = pps1_ok && pps2_ok && pps_x == 8'h00;
  wire pps_done = pcnt_q == plen;
  // The byte register follows the next index, so a take never shows the byte just taken.
  // The echo skips absent optional slots so that the check byte always goes out last.
  wire [7:0] atr_next = (idx_d == ATR_LAST) ? tck : atr_body(idx_d, atr_cfg_q, atr_gtb_q);
  wire [2:0] eidx = idx_d[2:0];
  wire [7:0] echo_next = (eidx == plen - 3'd1) ? pps_q[5]
                         : (eidx < 3'd2) ? pps_q[eidx]
                         : (eidx == 3'd2 && pps_q[1][4]) ? pps_q[2]
                         : (eidx == 3'd2 + {2'b0, pps_q[1][4]} && pps_q[1][5]) ? pps_q[3]
                         : pps_q[4];

  // Session sequencing; a reset level low always returns to the hold state.
  always_comb
  begin
    st_d = st_q;
    idx_d = idx_q;
    case (st_q)
      ST_HOLD: if (rst_rise) st_d = ST_ATR;
      ST_ATR:
        if (tx_nack) idx_d = idx_q - 4'h1; // RULE22
        else if (tx_take && idx_q == ATR_LAST) st_d = neg_q ? ST_WAIT : ST_RUN;
        else if (tx_take) idx_d = idx_q + 4'h1;
      ST_WAIT:
        if (rx_take) st_d = (rx_byte == PPSS) ? ST_PRX : ST_RUN;
      ST_PRX:
        if (pps_done)
        begin
          st_d = pps_ok ? ST_PTX : ST_RUN;
          idx_d = 4'h0;
        end
      ST_PTX:
        if (tx_nack) idx_d = idx_q - 4'h1; // RULE22
        else if (tx_take && idx_q == {1'b0, plen - 3'd1}) st_d = ST_RUN;
        else if (tx_take) idx_d = idx_q + 4'h1;
      ST_RUN: st_d = ST_RUN;
      default: st_d = ST_HOLD;
    endcase
    if (!card_rst_n)
    begin
      st_d = ST_HOLD;
      idx_d = 4'h0;
    end
  end

  // Control state and reset-mode handling.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_HOLD;
      idx_q <= 4'h0;
      crst_q <= 1'b0;
      cold_q <= 1'b1;
      sec_q <= 1'b0;
      neg_q <= 1'b1;
      fidi_q <= FD_DEF;
      lowimp_q <= 1'b0;
      rep_q <= 1'b0;
      atr_cfg_q <= '0;
      atr_gtb_q <= GTB_RST;
      pcnt_q <= 3'd0;
    end
    else if (en)
    begin
      st_q <= st_d;
      idx_q <= idx_d;
      crst_q <= card_rst_n;
      rep_q <= rx_valid & rx_perr; // RULE22
      if (!contact_act) cold_q <= 1'b1;
      if (rst_rise)
      begin
        cold_q <= 1'b0;
        sec_q <= 1'b0; // RULE13 RULE14
        if (cold_q)
        begin
          // Snapshot only at cold reset keeps every warm answer identical.
          atr_cfg_q <= cfg_q; // RULE15
          atr_gtb_q <= gtb_q;
          neg_q <= 1'b1; // RULE13
          fidi_q <= FD_DEF;
          lowimp_q <= 1'b0;
        end
        else if (!atr_cfg_q.spec) // RULE14
        begin
          neg_q <= 1'b1;
          fidi_q <= FD_DEF;
          lowimp_q <= 1'b0;
        end
        else neg_q <= 1'b0;
      end
      else if (wr && addr == OFS_SEC) sec_q <= wdata[0];
      if (st_q == ST_WAIT || st_q == ST_HOLD) pcnt_q <= 3'd0;
      if ((st_q == ST_WAIT || st_q == ST_PRX) && rx_take && !pps_done)
        pcnt_q <= pcnt_q + 3'd1;
      if (st_q == ST_PRX && pps_done && pps_ok)
      begin
        if (pps_q[1][4]) fidi_q <= pps_q[2]; // RULE3
        lowimp_q <= pps_q[1][5] & pfeat.lowimp; // RULE7
      end
    end
  end

  // PPS capture; absent optional bytes are zeroed so the check sum still holds.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int k = 0; k < 6; k++) pps_q[k] <= 8'h00;
    end
    else if (en)
    begin
      if (st_q == ST_WAIT && rx_take)
      begin
        for (int k = 1; k < 6; k++) pps_q[k] <= 8'h00;
        pps_q[0] <= rx_byte;
      end
      else if (st_q == ST_PRX && rx_take && !pps_done)
      begin
        if (pcnt_q == 3'd1) pps_q[1] <= rx_byte;
        else if (pcnt_q == 3'd2 && rx_byte != 8'h00 && pps_q[1][4]) pps_q[2] <= rx_byte;
        else if (pcnt_q == plen - 3'd1) pps_q[5] <= rx_byte;
        else if (pps_q[1][5] && pcnt_q == 3'd2 + {2'b0, pps_q[1][4]}) pps_q[3] <= rx_byte;
        else pps_q[4] <= rx_byte;
      end
    end
  end

  // Transmit byte register: answer bytes, then the PPS echo.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txv_q <= 1'b0;
      txb_q <= 8'h00;
    end
    else if (en)
    begin
      txv_q <= st_d == ST_ATR || st_d == ST_PTX;
      txb_q <= (st_d == ST_PTX) ? echo_next : atr_next;
    end
  end

  // Register slave; configuration is only picked up by the next cold reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q <= '{spec: 1'b0, stop: CFG_STOP_RST, vclass: CFG_CLASS_RST, ta1: CFG_TA1_RST};
      gtb_q <= GTB_RST;
      rdata_q <= 32'h0;
    end
    else if (en)
    begin
      if (wr && addr == OFS_CFG) cfg_q <= cfg_t'(wdata[16:0]);
      if (wr && addr == OFS_GTB) gtb_q <= wdata[7:0];
      rdata_q <= 32'h0;
      if (rd)
        case (addr)
          OFS_CFG: rdata_q <= {15'h0, cfg_q};
          OFS_GTB: rdata_q <= {24'h0, gtb_q};
          OFS_SEC: rdata_q <= {31'h0, sec_q};
          OFS_STAT: rdata_q <= {6'h0, gfeat, lowimp_q, fidi_q, neg_q, cold_q, 5'h0,
                                st_q};
          default: rdata_q <= 32'h0;
        endcase
    end
  end

  assign rdata = rdata_q;
  assign tx_byte = txb_q;
  assign tx_valid = txv_q;
  assign rx_repeat = rep_q;
  assign negotiable = neg_q;
  assign fidi = fidi_q;
  assign lowimp_sel = lowimp_q;
  assign security = sec_q;

  // Checks on the card's own behaviour; answer byte checks are taken on the byte actually presented.
  hist_first_a: assert property (st_q == ST_ATR && idx_q == 4'h7 && en |-> tx_byte == HIST_CAT)
    else $error("category byte wrong"); // RULE1
  hist_order_a: assert property (st_q == ST_ATR && idx_q == 4'ha |-> tx_byte == HIST_TAG_CAP)
    else $error("capability tag wrong"); // RULE2
  td_t15_a: assert property (st_q == ST_ATR && idx_q == 4'h4 |-> tx_byte[3:0] == 4'hf)
    else $error("T=15 not indicated"); // RULE5
  tb_zero_a: assert property (atr_gtb_q == 8'h00 |-> gfeat.none && !gfeat.lowimp)
    else $error("zero tB decode wrong"); // RULE6
  p2p_dec_a: assert property (gfeat.p2p |-> atr_gtb_q[7] && atr_gtb_q[3] && atr_gtb_q[2])
    else $error("p2p decode wrong"); // RULE9
  cold_neg_a: assert property (en && rst_rise && cold_q |=> neg_q && !sec_q && fidi_q == FD_DEF)
    else $error("cold reset mode wrong"); // RULE13
  warm_sec_a: assert property (en && rst_rise |=> !sec_q)
    else $error("security not cleared"); // RULE14
  warm_same_a: assert property (en && rst_rise && !cold_q |=> $stable(atr_cfg_q))
    else $error("answer changed in session"); // RULE15
  stop_ind_a: assert property (st_q == ST_ATR && idx_q == 4'h5 && atr_cfg_q.vclass != CLASS_A_ONLY
    |-> tx_byte[7:6] != STOP_NONE) else $error("clock stop not shown"); // RULE16
  nack_rep_a: assert property (en && st_q == ST_ATR && tx_nack && card_rst_n
    |=> idx_q == $past(idx_q) - 4'h1) else $error("no repetition"); // RULE22
  atr_done_c: cover property (st_q == ST_ATR ##1 st_q == ST_WAIT);
  pps_echo_c: cover property (st_q == ST_PTX ##1 st_q == ST_RUN);
  warm_spec_c: cover property (rst_rise && !cold_q && atr_cfg_q.spec);
endmodule : card_session

// >>> sim/tb.sv
// Self-checking bench for the card start-up session block.
`timescale 1ns/1ps
module tb;
  import card_pkg::*;
  logic clk, rst_n, en, contact_act, card_rst_n, wr, rd, slow, nack_en, fault_seen;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] tx_byte, rx_byte, fidi;
  logic tx_valid, tx_ready, tx_nack, rx_valid, rx_perr, rx_repeat;
  logic negotiable, lowimp_sel, security;
  logic [7:0] exp_atr[15];
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int repeats = 0;
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  card_session dut (.clk(clk), .rst_n(rst_n), .en(en), .contact_act(contact_act),
    .card_rst_n(card_rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_nack(tx_nack),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_perr(rx_perr), .rx_repeat(rx_repeat),
    .negotiable(negotiable), .fidi(fidi), .lowimp_sel(lowimp_sel), .security(security));
  term_model term (.clk(clk), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_nack(tx_nack), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_perr(rx_perr),
    .slow(slow), .nack_en(nack_en));
  task automatic tally_and_finish;
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  // Repeat requests must trail a flagged byte by one cycle; the cycle ceiling cuts hangs.
  always @(posedge clk)
  begin
    cycles++;
    if (rx_repeat)
    begin
      repeats++;
      check("repeat timing", 32'(fault_seen), 32'h1);
    end
    fault_seen <= rx_valid & rx_perr;
    if (cycles == 10000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("register read", rdata, exp);
  endtask : reg_rd
  // Cold when contacts were dropped during reset, warm otherwise.
  // A short answer is reset again, at most three resets in a row, before it is judged.
  task automatic card_reset(input logic cold);
    for (int t = 0; t < 3 && (t == 0 || term.got.size() < 15); t++)
    begin
      term.got.delete();
      @(posedge clk);
      card_rst_n <= 1'b0;
      contact_act <= ~cold;
      repeat (4) @(posedge clk);
      contact_act <= 1'b1;
      @(posedge clk);
      card_rst_n <= 1'b1;
      for (int i = 0; i < 300 && term.got.size() < 15; i++) @(posedge clk);
      repeat (4) @(posedge clk);
      #1;
    end
  endtask : card_reset
  task automatic atr_check(input logic [7:0] ta1, input logic [7:0] ta3);
    logic [7:0] x;
    x = 8'h00;
    exp_atr = '{ATR_TS, ATR_T0, ta1, ATR_TD1, ATR_TD2, ta3, 8'h90, 8'h80, 8'h31, HIST_SVC_VAL,
      8'h73, HIST_CAP_VAL[23:16], HIST_CAP_VAL[15:8], HIST_CAP_VAL[7:0], 8'h00};
    for (int i = 1; i < 14; i++) x ^= exp_atr[i];
    exp_atr[14] = x;
    check("atr length", term.got.size(), 15);
    for (int i = 0; i < 15 && i < term.got.size(); i++) check("atr", term.got[i], exp_atr[i]);
  endtask : atr_check
  // A negative echo count skips the echo comparison.
  task automatic pps(input logic [7:0] req[$], input int n_echo);
    term.got.delete();
    foreach (req[i]) term.send(req[i], 1'b0);
    repeat (30) @(posedge clk);
    #1;
    if (n_echo >= 0)
      check("echo length", term.got.size(), n_echo);
    for (int i = 0; i < n_echo && i < term.got.size(); i++) check("echo", term.got[i], req[i]);
  endtask : pps
  // Main sequence: sessions with cold and warm resets and PPS exchanges.
  initial
  begin
    rst_n = 1'b0;
    en = 1'b1;
    contact_act = 1'b0;
    card_rst_n = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    slow = 1'b1;
    nack_en = 1'b1;
    fault_seen = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("fidi", 32'(fidi), 32'h11);
    check("security", 32'(security), 32'h0);
    reg_rd(OFS_CFG, 32'h0000c397);
    reg_rd(4'h2, 32'h0);
    reg_wr(OFS_GTB, 32'h90);
    reg_wr(OFS_CFG, 32'h0001c397);
    card_reset(1'b1);
    atr_check(8'h97, 8'hc3);
    slow = 1'b0;
    term.send(PPSS, 1'b1);
    pps('{8'hff, 8'h10, 8'h95, 8'h7a}, 4);
    // The enable stands in for the card clock; a write while it is stopped must be lost.
    if (exp_atr[5][7:6] != STOP_NONE)
    begin
      repeat (1860) @(posedge clk);
      en <= 1'b0;
      reg_wr(OFS_SEC, 32'h1);
      en <= 1'b1;
      repeat (744) @(posedge clk);
    end
    check("security", 32'(security), 32'h0);
    check("fidi", 32'(fidi), 32'h95);
    reg_wr(OFS_SEC, 32'h1);
    reg_wr(OFS_CFG, 32'h00000295);
    check("security", 32'(security), 32'h1);
    card_reset(1'b0);
    atr_check(8'h97, 8'hc3);
    check("security", 32'(security), 32'h0);
    check("negotiable", 32'(negotiable), 32'h0);
    check("fidi", 32'(fidi), 32'h95);
    card_reset(1'b1);
    atr_check(8'h95, 8'hc2);
    check("negotiable", 32'(negotiable), 32'h1);
    check("fidi", 32'(fidi), 32'h11);
    pps('{8'hff, 8'h30, 8'h94, 8'h90, 8'hcb}, 5);
    check("fidi", 32'(fidi), 32'h94);
    check("low impedance", 32'(lowimp_sel), 32'h1);
    card_reset(1'b0);
    atr_check(8'h95, 8'hc2);
    check("negotiable", 32'(negotiable), 32'h1);
    check("low impedance", 32'(lowimp_sel), 32'h0);
    pps('{8'hff, 8'h10, 8'h13, 8'hfc}, 0);
    check("fidi", 32'(fidi), 32'h11);
    reg_rd(OFS_STAT, 32'h01004605);
    check("repeat count", repeats, 1);
    tally_and_finish();
  end
endmodule : tb

// >>> sim/term_model.sv
// Terminal-side partner model: takes card bytes and sends request bytes.
`timescale 1ns/1ps
module term_model (
  input wire logic clk,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_nack,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_perr,
  input wire logic slow,
  input wire logic nack_en
);
  logic [7:0] got[$];
  logic nacked = 1'b0;
  logic nk;
  initial
  begin
    tx_ready = 1'b0;
    tx_nack = 1'b0;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_perr = 1'b0;
  end
  // Logs taken bytes; when armed, rejects the fifth byte once and drops it from the log.
  always @(posedge clk)
  begin
    nk = nack_en && !nacked && tx_valid && tx_ready && got.size() == 4;
    if (nk)
      nacked = 1'b1;
    else if (tx_valid && tx_ready)
      got.push_back(tx_byte);
    tx_nack <= nk;
    tx_ready <= nk ? 1'b0 : (slow ? ~tx_ready : 1'b1);
  end
  // One request byte; the line then shows the inverse so stale data cannot pass.
  task automatic send(input logic [7:0] b, input logic perr);
    @(posedge clk);
    rx_byte <= b;
    rx_valid <= 1'b1;
    rx_perr <= perr;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_perr <= 1'b0;
    rx_byte <= ~b;
  endtask : send
endmodule : term_model
